// [event_irq.sv]
// Sticky event status with write-one-to-clear, event mask and interrupt level
`timescale 1ns/10ps
`default_nettype none

module event_irq #(
    parameter int unsigned N = 16,
    parameter logic [N-1:0] MASK_RESET = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] set,
    input wire logic clr_we,
    input wire logic [N-1:0] clr_data,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_data,
    output logic [N-1:0] status_q,
    output logic [N-1:0] mask_q,
    output logic irq_q
);

    logic [N-1:0] status_d;

    // ========================================================================
    // Set wins over a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            assign status_d[i] = set[i] | (status_q[i] & ~(clr_we & clr_data[i]));
        end
    endgenerate

    // Status, mask and interrupt flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q <= '0;
            mask_q <= MASK_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            mask_q <= mask_we ? mask_data : mask_q;
            irq_q <= |(status_q & ~mask_q);
        end
    end

endmodule
`default_nettype wire

// [fault_merge.sv]
// Masked OR of the supply fault flags and rising-edge detection per flag
`timescale 1ns/10ps
`default_nettype none

module fault_merge #(
    parameter int unsigned N = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] flags,
    input wire logic [N-1:0] block,
    output logic summary_q,
    output logic [N-1:0] rise
);

    logic [N-1:0] passed;
    logic [N-1:0] prev_q;

    // ========================================================================
    // Per-flag gating and edge detection
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            assign passed[i] = flags[i] & ~block[i];
            assign rise[i] = flags[i] & ~prev_q[i];
        end
    endgenerate

    // Summary and previous flag levels
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            summary_q <= 1'b0;
            prev_q <= '0;
        end
        else
        begin
            summary_q <= |passed;
            prev_q <= flags;
        end
    end

endmodule
`default_nettype wire

// [supply_fault_mask_aggregation.sv]
// Supply-fault masking register, summary bit and APB register slave
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - 16-bit read/write masking register at index 47h, resets to all zeros.
// - Bit 15 set blocks analog supply overvoltage from the summary.
// - Bit 14 set blocks analog supply undervoltage from the summary.
// - Bit 13 set blocks I/O supply overvoltage from the summary.
// - Bit 12 set blocks I/O supply undervoltage from the summary.
// - Bit 11 set blocks digital supply overvoltage from the summary.
// - Bit 10 set blocks digital supply undervoltage from the summary.
// - Bit 9 set blocks analog supply oscillation from the summary.
// - Bit 8 set blocks I/O supply oscillation from the summary.
// - Bit 7 set blocks digital supply oscillation from the summary.
// - Bit 6 set blocks analog regulator overtemperature warning from the summary.
// - Bit 5 set blocks I/O regulator overtemperature warning from the summary.
// - Bit 4 set blocks analog regulator current limit from the summary.
// - Bit 3 set blocks I/O regulator current limit from the summary.
// - Bit 2 set blocks first analog ground disconnect from the summary.
// - Bit 1 set blocks second analog ground disconnect from the summary.
// - Bit 0 set blocks digital ground disconnect from the summary.
module supply_fault_mask_aggregation (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [supply_fault_pkg::ADDR_W-1:0] paddr,
    input wire logic [supply_fault_pkg::DATA_W-1:0] pwdata,
    output logic [supply_fault_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic analog_supply_overvoltage_flag,
    input wire logic analog_supply_undervoltage_flag,
    input wire logic io_supply_overvoltage_flag,
    input wire logic io_supply_undervoltage_flag,
    input wire logic digital_supply_overvoltage_flag,
    input wire logic digital_supply_undervoltage_flag,
    input wire logic analog_supply_oscillation_flag,
    input wire logic io_supply_oscillation_flag,
    input wire logic digital_supply_oscillation_flag,
    input wire logic analog_regulator_overtemp_flag,
    input wire logic io_regulator_overtemp_flag,
    input wire logic analog_regulator_current_limit_flag,
    input wire logic io_regulator_current_limit_flag,
    input wire logic analog_ground_one_disconnect_flag,
    input wire logic analog_ground_two_disconnect_flag,
    input wire logic digital_ground_disconnect_flag,
    output logic supply_fault_summary,
    output logic irq
);

    import supply_fault_pkg::*;

    logic [FLAG_COUNT-1:0] src_flags;
    logic [FLAG_COUNT-1:0] mask_q;
    logic [FLAG_COUNT-1:0] flag_rise;
    logic [FLAG_COUNT-1:0] event_status;
    logic [FLAG_COUNT-1:0] irq_mask;
    logic summary_q;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic first_access;
    logic done;
    logic wr_done;
    logic hit_mask;
    logic hit_flags;
    logic hit_event;
    logic hit_irqm;
    logic mapped;
    logic wr_mask;
    logic wr_event;
    logic wr_irqm;
    logic [DATA_W-1:0] rdata;

    // ========================================================================
    // Source flags gathered into the masking register layout
    assign src_flags[ANALOG_SUPPLY_OVERVOLTAGE_BLOCK] = analog_supply_overvoltage_flag;
    assign src_flags[ANALOG_SUPPLY_UNDERVOLTAGE_BLOCK] = analog_supply_undervoltage_flag;
    assign src_flags[IO_SUPPLY_OVERVOLTAGE_BLOCK] = io_supply_overvoltage_flag;
    assign src_flags[IO_SUPPLY_UNDERVOLTAGE_BLOCK] = io_supply_undervoltage_flag;
    assign src_flags[DIGITAL_SUPPLY_OVERVOLTAGE_BLOCK] = digital_supply_overvoltage_flag;
    assign src_flags[DIGITAL_SUPPLY_UNDERVOLTAGE_BLOCK] = digital_supply_undervoltage_flag;
    assign src_flags[ANALOG_SUPPLY_OSCILLATION_BLOCK] = analog_supply_oscillation_flag;
    assign src_flags[IO_SUPPLY_OSCILLATION_BLOCK] = io_supply_oscillation_flag;
    assign src_flags[DIGITAL_SUPPLY_OSCILLATION_BLOCK] = digital_supply_oscillation_flag;
    assign src_flags[ANALOG_REGULATOR_OVERTEMP_BLOCK] = analog_regulator_overtemp_flag;
    assign src_flags[IO_REGULATOR_OVERTEMP_BLOCK] = io_regulator_overtemp_flag;
    assign src_flags[ANALOG_REGULATOR_CURRENT_LIMIT_BLOCK] =
        analog_regulator_current_limit_flag;
    assign src_flags[IO_REGULATOR_CURRENT_LIMIT_BLOCK] = io_regulator_current_limit_flag;
    assign src_flags[ANALOG_GROUND_ONE_DISCONNECT_BLOCK] =
        analog_ground_one_disconnect_flag;
    assign src_flags[ANALOG_GROUND_TWO_DISCONNECT_BLOCK] =
        analog_ground_two_disconnect_flag;
    assign src_flags[DIGITAL_GROUND_DISCONNECT_BLOCK] = digital_ground_disconnect_flag;

    // ========================================================================
    // APB phase tracking; one wait state so read data comes from a flop
    assign first_access = psel & penable & ~pready_q;
    assign done = psel & penable & pready_q;
    assign wr_done = done & pwrite;

    // Address decode, full word compare so misaligned addresses are unmapped
    assign hit_mask = (paddr == SUPPLY_FAULT_MASKING_ADDR);
    assign hit_flags = (paddr == FLAG_STATUS_ADDR);
    assign hit_event = (paddr == EVENT_STATUS_ADDR);
    assign hit_irqm = (paddr == EVENT_IRQ_MASK_ADDR);
    assign mapped = hit_mask | hit_flags | hit_event | hit_irqm;

    // Write strobes, effective only at the completing edge
    assign wr_mask = wr_done & hit_mask;
    assign wr_event = wr_done & hit_event;
    assign wr_irqm = wr_done & hit_irqm;

    // Read data select; upper bits read as zero, except the summary at bit 16 of flag status
    assign rdata = hit_mask ? {16'h0000, mask_q} :
                   hit_flags ? {15'h0000, summary_q, src_flags} :
                   hit_event ? {16'h0000, event_status} :
                   hit_irqm ? {16'h0000, irq_mask} :
                   READ_ZERO;

    // ========================================================================
    // APB answer flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= READ_ZERO;
        end
        else
        begin
            pready_q <= first_access;
            if (first_access)
            begin
                pslverr_q <= ~mapped;
                prdata_q <= pwrite ? READ_ZERO : rdata;
            end
        end
    end

    // Supply-fault masking register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= SUPPLY_FAULT_MASKING_RESET;
        end
        else if (wr_mask)
        begin
            mask_q <= pwdata[FLAG_COUNT-1:0];
        end
    end

    // ========================================================================
    // Masked summary and per-flag rising edges
    fault_merge #(
        .N(FLAG_COUNT)
    ) u_merge (
        .clk(pclk),
        .rst_n(presetn),
        .flags(src_flags),
        .block(mask_q),
        .summary_q(summary_q),
        .rise(flag_rise)
    );

    // Sticky flag events and the interrupt line; raw flags, not the mask, feed it
    event_irq #(
        .N(FLAG_COUNT),
        .MASK_RESET(EVENT_IRQ_MASK_RESET)
    ) u_irq (
        .clk(pclk),
        .rst_n(presetn),
        .set(flag_rise),
        .clr_we(wr_event),
        .clr_data(pwdata[FLAG_COUNT-1:0]),
        .mask_we(wr_irqm),
        .mask_data(pwdata[FLAG_COUNT-1:0]),
        .status_q(event_status),
        .mask_q(irq_mask),
        .irq_q(irq_q)
    );

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign supply_fault_summary = summary_q;
    assign irq = irq_q;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A completed write lands in the masking register on the next cycle
    property p_mask_write;
        wr_mask |=> (mask_q == $past(pwdata[FLAG_COUNT-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("masking register did not take the written value");

    // Without a write the masking register keeps its value
    property p_mask_hold;
        !wr_mask |=> (mask_q == $past(mask_q));
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("masking register changed without a write");

    // Any unmasked flag raises the summary one cycle later
    property p_summary_set;
        (|(src_flags & ~mask_q)) |=> supply_fault_summary;
    endproperty
    a_summary_set: assert property (p_summary_set)
        else $error("unmasked flag did not raise the summary");

    // With nothing unmasked the summary falls one cycle later
    property p_summary_clear;
        ((src_flags & ~mask_q) == 16'h0000) |=> !supply_fault_summary;
    endproperty
    a_summary_clear: assert property (p_summary_clear)
        else $error("summary high with every active flag masked");

    // A masked flag alone never reaches the summary, checked per bit
    genvar k;
    generate
        for (k = 0; k < FLAG_COUNT; k++)
        begin : g_chk
            property p_bit_block;
                (src_flags[k] && mask_q[k] && ((src_flags & ~mask_q) == 16'h0000))
                    |=> !supply_fault_summary;
            endproperty
            a_bit_block: assert property (p_bit_block)
                else $error("masked flag reached the summary");
        end
    endgenerate

    // Raw flags read back regardless of mask
    property p_raw_read;
        (first_access && hit_flags && !pwrite)
            |=> pready && (prdata[FLAG_COUNT-1:0] == $past(src_flags));
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("flag status read did not return raw flags");

    // A flag rising edge is recorded as an event even while masked
    property p_event_capture;
        (flag_rise != 16'h0000) |=> ((event_status & $past(flag_rise)) == $past(flag_rise));
    endproperty
    a_event_capture: assert property (p_event_capture)
        else $error("flag edge was not captured in event status");

    // Interrupt follows unmasked sticky events with one cycle delay
    property p_irq_level;
        (|(event_status & ~irq_mask)) |=> irq ##1 1'b1;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt low with an unmasked event pending");

    // Ready is a single-cycle answer, one wait state after the access phase opens
    property p_ready_pulse;
        first_access |=> pready ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready did not pulse for exactly one cycle");

    // Unmapped addresses answer with an error
    property p_unmapped;
        (first_access && !mapped) |=> (pready && pslverr && (prdata == READ_ZERO));
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access did not report an error");

endmodule
`default_nettype wire

// [supply_fault_mask_aggregation_bench.sv]
// Self-checking bench for the supply-fault masking register and its summary bit
`timescale 1ns/10ps
`default_nettype none

module supply_fault_mask_aggregation_bench;
    import supply_fault_pkg::*;

    // ========================================================================
    // Signals
    typedef struct {string what; logic [31:0] data; logic err;} note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] flags = 16'h0000;
    logic supply_fault_summary;
    logic irq;
    int n_fail = 0;
    int n_compared = 0;
    integer seed = 32'h1ed0_7659;
    note_t notes[$];

    // Clock at 50 MHz
    always #10 pclk = ~pclk;

    // ========================================================================
    // Device under test, each flag port fed from its mask bit position
    supply_fault_mask_aggregation i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .analog_supply_overvoltage_flag(flags[ANALOG_SUPPLY_OVERVOLTAGE_BLOCK]),
        .analog_supply_undervoltage_flag(flags[ANALOG_SUPPLY_UNDERVOLTAGE_BLOCK]),
        .io_supply_overvoltage_flag(flags[IO_SUPPLY_OVERVOLTAGE_BLOCK]),
        .io_supply_undervoltage_flag(flags[IO_SUPPLY_UNDERVOLTAGE_BLOCK]),
        .digital_supply_overvoltage_flag(flags[DIGITAL_SUPPLY_OVERVOLTAGE_BLOCK]),
        .digital_supply_undervoltage_flag(flags[DIGITAL_SUPPLY_UNDERVOLTAGE_BLOCK]),
        .analog_supply_oscillation_flag(flags[ANALOG_SUPPLY_OSCILLATION_BLOCK]),
        .io_supply_oscillation_flag(flags[IO_SUPPLY_OSCILLATION_BLOCK]),
        .digital_supply_oscillation_flag(flags[DIGITAL_SUPPLY_OSCILLATION_BLOCK]),
        .analog_regulator_overtemp_flag(flags[ANALOG_REGULATOR_OVERTEMP_BLOCK]),
        .io_regulator_overtemp_flag(flags[IO_REGULATOR_OVERTEMP_BLOCK]),
        .analog_regulator_current_limit_flag(flags[ANALOG_REGULATOR_CURRENT_LIMIT_BLOCK]),
        .io_regulator_current_limit_flag(flags[IO_REGULATOR_CURRENT_LIMIT_BLOCK]),
        .analog_ground_one_disconnect_flag(flags[ANALOG_GROUND_ONE_DISCONNECT_BLOCK]),
        .analog_ground_two_disconnect_flag(flags[ANALOG_GROUND_TWO_DISCONNECT_BLOCK]),
        .digital_ground_disconnect_flag(flags[DIGITAL_GROUND_DISCONNECT_BLOCK]),
        .supply_fault_summary(supply_fault_summary),
        .irq(irq)
    );

    // ========================================================================
    // Compare tasks, one per kind of result
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask

    // Closing report, the single place where the run ends
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========================================================================
    // APB master: setup, access until pready, then release; expectation goes to the queue
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wdata,
                       input logic [31:0] exp, input logic exp_err);
        int k;
        notes.push_back('{wr ? "write data" : "read data", exp, exp_err});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            $display("unexpected pready: expected 1, seen 0");
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Let n edges pass and step off the edge so outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Watcher: pops the oldest note whenever an APB answer shows
    always @(posedge pclk)
    begin
        if (presetn === 1'b1 && pready === 1'b1)
        begin
            if (notes.size() == 0)
                check_bit("answer without request", 1'b0, 1'b1);
            else
            begin
                note_t n;
                n = notes.pop_front();
                check_word(n.what, n.data, prdata);
                check_bit("pslverr", n.err, pslverr);
            end
        end
    end

    // ========================================================================
    // Main sequence
    initial
    begin
        logic [15:0] m;
        logic [31:0] r;
        logic s;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the masking and interrupt mask registers
        apb(1'b0, SUPPLY_FAULT_MASKING_ADDR, '0, 32'h0000_0000, 1'b0);
        apb(1'b0, EVENT_IRQ_MASK_ADDR, '0, 32'h0000_0000, 1'b0);
        // Each source alone: own mask bit blocks it, all other bits set lets it through
        for (int i = 0; i < 16; i++)
        begin
            m = 16'h0001 << i;
            flags <= m;
            apb(1'b1, SUPPLY_FAULT_MASKING_ADDR, {16'hffff, m}, 32'h0000_0000, 1'b0);
            settle(2);
            check_bit("summary masked", 1'b0, supply_fault_summary);
            apb(1'b0, FLAG_STATUS_ADDR, '0, {16'h0000, m}, 1'b0);
            apb(1'b1, SUPPLY_FAULT_MASKING_ADDR, {16'h0000, ~m}, 32'h0000_0000, 1'b0);
            settle(2);
            check_bit("summary unmasked", 1'b1, supply_fault_summary);
        end
        // Random flags and masks against the masked OR
        for (int j = 0; j < 24; j++)
        begin
            r = $random(seed);
            m = r[31:16] & $random(seed);
            flags <= r[15:0];
            apb(1'b1, SUPPLY_FAULT_MASKING_ADDR, {r[7:0], r[31:8]}, 32'h0000_0000, 1'b0);
            m = r[23:8];
            settle(2);
            s = |(r[15:0] & ~m);
            check_bit("summary", s, supply_fault_summary);
            apb(1'b0, SUPPLY_FAULT_MASKING_ADDR, '0, {16'h0000, m}, 1'b0);
            apb(1'b0, FLAG_STATUS_ADDR, '0, {15'h0000, s, r[15:0]}, 1'b0);
        end
        // Unmapped access errors; write to the read-only flag status is ignored
        apb(1'b1, 12'hffc, 32'hffff_ffff, 32'h0000_0000, 1'b1);
        apb(1'b0, 12'hffc, '0, 32'h0000_0000, 1'b1);
        apb(1'b1, FLAG_STATUS_ADDR, 32'h0000_ffff, 32'h0000_0000, 1'b0);
        apb(1'b0, SUPPLY_FAULT_MASKING_ADDR, '0, {16'h0000, m}, 1'b0);
        // Interrupt: clear all, raise one event, mask, unmask, clear
        flags <= 16'h0000;
        apb(1'b1, SUPPLY_FAULT_MASKING_ADDR, 32'h0000_0000, 32'h0000_0000, 1'b0);
        settle(2);
        apb(1'b1, EVENT_STATUS_ADDR, 32'h0000_ffff, 32'h0000_0000, 1'b0);
        settle(2);
        check_bit("irq idle", 1'b0, irq);
        check_bit("summary idle", 1'b0, supply_fault_summary);
        flags <= 16'h0004;
        settle(3);
        check_bit("irq raised", 1'b1, irq);
        apb(1'b0, EVENT_STATUS_ADDR, '0, 32'h0000_0004, 1'b0);
        apb(1'b1, EVENT_IRQ_MASK_ADDR, 32'h0000_0004, 32'h0000_0000, 1'b0);
        settle(2);
        check_bit("irq masked", 1'b0, irq);
        apb(1'b1, EVENT_IRQ_MASK_ADDR, 32'h0000_0000, 32'h0000_0000, 1'b0);
        settle(2);
        check_bit("irq unmasked", 1'b1, irq);
        apb(1'b1, EVENT_STATUS_ADDR, 32'h0000_0004, 32'h0000_0000, 1'b0);
        settle(2);
        check_bit("irq cleared", 1'b0, irq);
        check_bit("summary level", 1'b1, supply_fault_summary);
        apb(1'b0, EVENT_STATUS_ADDR, '0, 32'h0000_0000, 1'b0);
        settle(2);
        check_word("pending notes", 32'h0000_0000, notes.size());
        give_verdict();
    end
endmodule

`default_nettype wire

// [supply_fault_pkg.sv]
// Package with register map, field positions and widths for the supply-fault mask block
package supply_fault_pkg;

    // ========================================================================
    // Sizes
    localparam int unsigned FLAG_COUNT = 16;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ========================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] SUPPLY_FAULT_MASKING_IDX = 8'h47;
    localparam logic [7:0] FLAG_STATUS_IDX = 8'h60;
    localparam logic [7:0] EVENT_STATUS_IDX = 8'h61;
    localparam logic [7:0] EVENT_IRQ_MASK_IDX = 8'h62;

    localparam logic [ADDR_W-1:0] SUPPLY_FAULT_MASKING_ADDR = {2'h0, SUPPLY_FAULT_MASKING_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] FLAG_STATUS_ADDR = {2'h0, FLAG_STATUS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = {2'h0, EVENT_STATUS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] EVENT_IRQ_MASK_ADDR = {2'h0, EVENT_IRQ_MASK_IDX, 2'h0};

    // ========================================================================
    // Reset values
    localparam logic [FLAG_COUNT-1:0] SUPPLY_FAULT_MASKING_RESET = 16'h0000;
    localparam logic [FLAG_COUNT-1:0] EVENT_IRQ_MASK_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ========================================================================
    // Bit positions of the masking register (same layout for flags and events)
    localparam int unsigned ANALOG_SUPPLY_OVERVOLTAGE_BLOCK = 15;
    localparam int unsigned ANALOG_SUPPLY_UNDERVOLTAGE_BLOCK = 14;
    localparam int unsigned IO_SUPPLY_OVERVOLTAGE_BLOCK = 13;
    localparam int unsigned IO_SUPPLY_UNDERVOLTAGE_BLOCK = 12;
    localparam int unsigned DIGITAL_SUPPLY_OVERVOLTAGE_BLOCK = 11;
    localparam int unsigned DIGITAL_SUPPLY_UNDERVOLTAGE_BLOCK = 10;
    localparam int unsigned ANALOG_SUPPLY_OSCILLATION_BLOCK = 9;
    localparam int unsigned IO_SUPPLY_OSCILLATION_BLOCK = 8;
    localparam int unsigned DIGITAL_SUPPLY_OSCILLATION_BLOCK = 7;
    localparam int unsigned ANALOG_REGULATOR_OVERTEMP_BLOCK = 6;
    localparam int unsigned IO_REGULATOR_OVERTEMP_BLOCK = 5;
    localparam int unsigned ANALOG_REGULATOR_CURRENT_LIMIT_BLOCK = 4;
    localparam int unsigned IO_REGULATOR_CURRENT_LIMIT_BLOCK = 3;
    localparam int unsigned ANALOG_GROUND_ONE_DISCONNECT_BLOCK = 2;
    localparam int unsigned ANALOG_GROUND_TWO_DISCONNECT_BLOCK = 1;
    localparam int unsigned DIGITAL_GROUND_DISCONNECT_BLOCK = 0;

    // Summary bit position inside the flag status register
    localparam int unsigned SUMMARY_BIT = 16;

endpackage
